// file: hw/asd_consts.vh
`ifndef ASD_CONSTS_VH
`define ASD_CONSTS_VH

// ****************************************
// register indices (byte address = 4 x index)
// ****************************************
`define ASD_IDX_RGTC   6'h1F
`define ASD_IDX_LGAIN  6'h20
`define ASD_IDX_RGAIN  6'h21
`define ASD_IDX_LDEB   6'h22
`define ASD_IDX_RDEB   6'h23
`define ASD_IDX_FLAGS  6'h24
`define ASD_IDX_CTRL   6'h30
`define ASD_IDX_LMAX   6'h31
`define ASD_IDX_RMAX   6'h32
`define ASD_IDX_ISTS   6'h33
`define ASD_IDX_ICLR   6'h34
`define ASD_IDX_IEN    6'h35
`define ASD_IDX_LGTC   6'h36

// ****************************************
// field positions
// ****************************************
`define ASD_HYST_HI    7
`define ASD_HYST_LO    6
`define ASD_THR_HI     5
`define ASD_THR_LO     1
`define ASD_CLIP_BIT   0
`define ASD_NDEB_HI    7
`define ASD_NDEB_LO    3
`define ASD_SDEB_HI    2
`define ASD_SDEB_LO    0
`define ASD_MAX_HI     7
`define ASD_MAX_LO     1
`define ASD_CTRL_LEN   0
`define ASD_CTRL_REN   1
`define ASD_CTRL_DRA   2

// ****************************************
// reset values
// ****************************************
`define ASD_RST_GTC    8'h00
`define ASD_RST_DEB    8'h00
`define ASD_RST_MAX    7'h7F
`define ASD_RST_CTRL   3'h0
`define ASD_RST_IEN    8'h00
`define ASD_RST_GAIN   8'h00

// ****************************************
// values and timing
// ****************************************
`define ASD_MAX_CAP    7'h77
`define ASD_THR_BASE   7'h1C
`define ASD_DEB_UNIT_US 500
`define ASD_FS_HZ_NOM  48000

`endif

// file: hw/asd_agc_regs.v
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "asd_consts.vh"

module asd_agc_regs #(
    parameter FS_HZ = `ASD_FS_HZ_NOM
) (
    // clock and reset
    input  wire        CLK,
    input  wire        RST,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // sample timing
    input  wire        FS_TICK,
    // left agc core
    input  wire [7:0]  L_AGC_GAIN,
    input  wire [6:0]  L_PGA_APPLIED,
    input  wire [6:0]  L_PGA_PROGRAMMED,
    input  wire        L_ADC_POWERED,
    input  wire [6:0]  L_SIG_ATTEN,
    // right agc core
    input  wire [7:0]  R_AGC_GAIN,
    input  wire [6:0]  R_PGA_APPLIED,
    input  wire [6:0]  R_PGA_PROGRAMMED,
    input  wire        R_ADC_POWERED,
    input  wire [6:0]  R_SIG_ATTEN,
    // controls to agc core
    output wire        L_AGC_EN,
    output wire        R_AGC_EN,
    output wire [6:0]  L_MAX_GAIN,
    output wire [6:0]  R_MAX_GAIN,
    output wire        L_CLIP_STEP_EN,
    output wire        R_CLIP_STEP_EN,
    output wire        L_SIG_BELOW,
    output wire        R_SIG_BELOW,
    output wire        DOUBLE_RATE_AUDIO,
    // interrupt
    output wire        IRQ
);

    // ****************************************
    // constants and functions
    // ****************************************

    // samples per half-millisecond debounce unit
    // an FS_HZ under 2000 gives a zero unit and breaks timing
    localparam integer SPU = (FS_HZ * `ASD_DEB_UNIT_US) / 1000000;
    localparam [15:0]  SPU_LAST = SPU[15:0] - 16'h0001;

    // debounce code to half-ms units
    function [11:0] deb_units;
        input [4:0] code;
        reg   [4:0] m;
        begin
            m = code - 5'h07;
            case (code)
                5'h00:   deb_units = 12'h000;
                5'h01:   deb_units = 12'h001;
                5'h02:   deb_units = 12'h002;
                5'h03:   deb_units = 12'h004;
                5'h04:   deb_units = 12'h008;
                5'h05:   deb_units = 12'h010;
                5'h06:   deb_units = 12'h020;
                5'h07:   deb_units = 12'h040;
                // code 30 gives 1472 ms, code 31 gives 1536 ms
                default: deb_units = {m, 7'h00};
            endcase
        end
    endfunction

    // hysteresis code to dB
    function [1:0] hyst_db;
        input [1:0] code;
        begin
            case (code)
                2'h0:    hyst_db = 2'h1;
                2'h1:    hyst_db = 2'h2;
                2'h2:    hyst_db = 2'h3;
                default: hyst_db = 2'h0;
            endcase
        end
    endfunction

    // index is a mapped register
    function is_mapped;
        input [5:0] idx;
        begin
            case (idx)
                `ASD_IDX_RGTC, `ASD_IDX_LGAIN, `ASD_IDX_RGAIN,
                `ASD_IDX_LDEB, `ASD_IDX_RDEB, `ASD_IDX_FLAGS,
                `ASD_IDX_CTRL, `ASD_IDX_LMAX, `ASD_IDX_RMAX,
                `ASD_IDX_ISTS, `ASD_IDX_ICLR, `ASD_IDX_IEN,
                `ASD_IDX_LGTC: is_mapped = 1'b1;
                default:       is_mapped = 1'b0;
            endcase
        end
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    // readouts are flops, so reading them disturbs nothing
    reg  [7:0]  rgtc_reg;      // right gate/threshold/clip
    reg  [7:0]  lgtc_reg;      // left gate/threshold/clip
    reg  [7:0]  ldeb_reg;      // left debounce
    reg  [7:0]  rdeb_reg;      // right debounce
    reg  [2:0]  ctrl_reg;      // agc enables, double rate
    reg  [6:0]  lmax_reg;      // left max gain
    reg  [6:0]  rmax_reg;      // right max gain
    reg  [7:0]  ien_reg;       // interrupt enable
    reg  [7:0]  ists_reg;      // sticky interrupt status
    reg  [7:0]  flags_reg;     // converter flags
    reg  [31:0] prdata_reg;    // read data
    reg         err_reg;       // unmapped access
    reg  [7:0]  rd_next;       // read mux
    wire [5:0]  idx;           // register index
    wire        hit;           // aligned and mapped
    wire        wr;            // write strobe
    wire [7:0]  flags_next;    // live flags
    wire [15:0] gtc_v;         // per-channel gate ctrl
    wire [15:0] deb_v;         // per-channel debounce
    wire [13:0] max_v;         // per-channel max gain
    wire [15:0] gain_in;       // per-channel agc gain
    wire [13:0] pga_app;       // per-channel pga applied
    wire [13:0] pga_prg;       // per-channel pga programmed
    wire [1:0]  pwr_in;        // per-channel power
    wire [13:0] att_in;        // per-channel signal atten
    wire [1:0]  en_v;          // per-channel agc enable
    wire [15:0] gain_v;        // per-channel readout
    wire [1:0]  below_v;       // per-channel below flag
    wire [7:0]  rise;          // flag rising edges

    assign idx     = PADDR[7:2];
    assign hit     = (PADDR[1:0] == 2'h0) && is_mapped(idx);
    assign wr      = PSEL && PENABLE && PWRITE && hit;
    assign gtc_v   = {rgtc_reg, lgtc_reg};
    assign deb_v   = {rdeb_reg, ldeb_reg};
    assign max_v   = {rmax_reg, lmax_reg};
    assign gain_in = {R_AGC_GAIN, L_AGC_GAIN};
    assign pga_app = {R_PGA_APPLIED, L_PGA_APPLIED};
    assign pga_prg = {R_PGA_PROGRAMMED, L_PGA_PROGRAMMED};
    assign pwr_in  = {R_ADC_POWERED, L_ADC_POWERED};
    assign att_in  = {R_SIG_ATTEN, L_SIG_ATTEN};
    assign en_v    = {ctrl_reg[`ASD_CTRL_REN], ctrl_reg[`ASD_CTRL_LEN]};

    // ****************************************
    // per-channel detection and readouts
    // ****************************************
    // channel 0 is left, channel 1 is right throughout
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            wire [7:0]  gtc  = gtc_v[ch*8 +: 8];
            wire [7:0]  deb  = deb_v[ch*8 +: 8];
            wire [4:0]  thr  = gtc[`ASD_THR_HI:`ASD_THR_LO];
            wire [6:0]  att  = att_in[ch*7 +: 7];
            wire        en   = en_v[ch];
            // threshold in dB below full scale
            wire [6:0]  thr_db = `ASD_THR_BASE + {1'b0, thr, 1'b0};
            wire [1:0]  hy   = hyst_db(gtc[`ASD_HYST_HI:`ASD_HYST_LO]);
            wire        det_en = en && (thr != 5'h00);
            reg         below_reg;   // debounced below flag
            reg  [11:0] unit_cnt;    // elapsed half-ms units
            reg  [15:0] smp_cnt;     // samples within unit
            reg  [7:0]  gain_reg;    // applied gain readout
            reg         settled_reg; // pga settled
            wire        raw;
            wire [11:0] target;
            wire [6:0]  max_eff;

            // leave below only once hysteresis is cleared
            assign raw = below_reg ?
                !(({1'b0, att} + {6'h00, hy}) < {1'b0, thr_db}) :
                (att > thr_db);
            // noise debounce entering, signal debounce leaving
            assign target = raw ?
                deb_units(deb[`ASD_NDEB_HI:`ASD_NDEB_LO]) :
                deb_units({2'h0, deb[`ASD_SDEB_HI:`ASD_SDEB_LO]});
            // codes above 59.5 dB behave as 59.5 dB
            assign max_eff = (max_v[ch*7 +: 7] > `ASD_MAX_CAP) ?
                `ASD_MAX_CAP : max_v[ch*7 +: 7];

            // debounce counter on sample ticks
            always @(posedge CLK or posedge RST) begin
                if (RST) begin
                    below_reg <= 1'b0;
                    unit_cnt  <= 12'h000;
                    smp_cnt   <= 16'h0000;
                end else if (!det_en) begin
                    // detection off
                    below_reg <= 1'b0;
                    unit_cnt  <= 12'h000;
                    smp_cnt   <= 16'h0000;
                end else if (raw == below_reg) begin
                    // no pending change
                    unit_cnt  <= 12'h000;
                    smp_cnt   <= 16'h0000;
                end else if (unit_cnt >= target) begin
                    // debounce satisfied
                    below_reg <= raw;
                    unit_cnt  <= 12'h000;
                    smp_cnt   <= 16'h0000;
                end else if (FS_TICK) begin
                    // tick rate doubles under double rate audio
                    if (smp_cnt >= SPU_LAST) begin
                        smp_cnt  <= 16'h0000;
                        unit_cnt <= unit_cnt + 12'h001;
                    end else begin
                        smp_cnt  <= smp_cnt + 16'h0001;
                    end
                end
            end

            // live gain and settle tracking
            always @(posedge CLK or posedge RST) begin
                if (RST) begin
                    gain_reg    <= `ASD_RST_GAIN;
                    settled_reg <= 1'b0;
                end else begin
                    gain_reg    <= en ? gain_in[ch*8 +: 8] :
                                   `ASD_RST_GAIN;
                    settled_reg <= (pga_app[ch*7 +: 7] ==
                                    pga_prg[ch*7 +: 7]);
                end
            end

            assign gain_v[ch*8 +: 8] = gain_reg;
            assign below_v[ch]       = below_reg;
            // nibble: settled, power, below, saturated
            assign flags_next[4 - ch*4 +: 4] = {
                settled_reg,
                pwr_in[ch],
                below_reg,
                en && (gain_reg == {1'b0, max_eff})
            };
        end
    endgenerate

    // ****************************************
    // flags and interrupts
    // ****************************************
    // rising edges only, so a flag held high raises one event
    assign rise = flags_next & ~flags_reg;

    // settled and saturated flags lag core inputs by two cycles (readout flop, flag flop); power lags by one
    // flag capture and sticky status, set wins over clear
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            flags_reg <= 8'h00;
            ists_reg  <= 8'h00;
        end else begin
            flags_reg <= flags_next;
            if (wr && idx == `ASD_IDX_ICLR) begin
                ists_reg <= (ists_reg & ~PWDATA[7:0]) | rise;
            end else begin
                ists_reg <= ists_reg | rise;
            end
        end
    end

    // level output, drops as soon as the bit is cleared or masked
    assign IRQ = |(ists_reg & ien_reg);

    // ****************************************
    // apb writes
    // ****************************************

    // writable registers; read-only targets ignore writes
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            rgtc_reg <= `ASD_RST_GTC;
            lgtc_reg <= `ASD_RST_GTC;
            ldeb_reg <= `ASD_RST_DEB;
            rdeb_reg <= `ASD_RST_DEB;
            ctrl_reg <= `ASD_RST_CTRL;
            lmax_reg <= `ASD_RST_MAX;
            rmax_reg <= `ASD_RST_MAX;
            ien_reg  <= `ASD_RST_IEN;
        end else if (wr) begin
            case (idx)
                `ASD_IDX_RGTC: rgtc_reg <= PWDATA[7:0];
                `ASD_IDX_LGTC: lgtc_reg <= PWDATA[7:0];
                `ASD_IDX_LDEB: ldeb_reg <= PWDATA[7:0];
                `ASD_IDX_RDEB: rdeb_reg <= PWDATA[7:0];
                `ASD_IDX_CTRL: ctrl_reg <= PWDATA[2:0];
                `ASD_IDX_LMAX: lmax_reg <= PWDATA[`ASD_MAX_HI:`ASD_MAX_LO];
                `ASD_IDX_RMAX: rmax_reg <= PWDATA[`ASD_MAX_HI:`ASD_MAX_LO];
                `ASD_IDX_IEN:  ien_reg  <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // apb reads
    // ****************************************

    // read mux, no side effects
    always @* begin
        case (idx)
            `ASD_IDX_RGTC:  rd_next = rgtc_reg;
            `ASD_IDX_LGTC:  rd_next = lgtc_reg;
            `ASD_IDX_LGAIN: rd_next = gain_v[7:0];
            `ASD_IDX_RGAIN: rd_next = gain_v[15:8];
            `ASD_IDX_LDEB:  rd_next = ldeb_reg;
            `ASD_IDX_RDEB:  rd_next = rdeb_reg;
            `ASD_IDX_FLAGS: rd_next = flags_reg;
            `ASD_IDX_CTRL:  rd_next = {5'h00, ctrl_reg};
            `ASD_IDX_LMAX:  rd_next = {lmax_reg, 1'b0};
            `ASD_IDX_RMAX:  rd_next = {rmax_reg, 1'b0};
            `ASD_IDX_ISTS:  rd_next = ists_reg;
            `ASD_IDX_IEN:   rd_next = ien_reg;
            default:        rd_next = 8'h00;
        endcase
    end

    // capture in setup keeps prdata steady through the access phase
    // sample read data and decode in setup phase
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            prdata_reg <= 32'h00000000;
            err_reg    <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            prdata_reg <= hit ? {24'h000000, rd_next} : 32'h00000000;
            err_reg    <= !hit;
        end
    end

    // no wait states, every access ends in its first access cycle
    assign PRDATA  = prdata_reg;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && err_reg;

    // ****************************************
    // control outputs
    // ****************************************
    // raw max gain codes go out; the 0x77 cap is only for the flag
    assign L_AGC_EN          = ctrl_reg[`ASD_CTRL_LEN];
    assign R_AGC_EN          = ctrl_reg[`ASD_CTRL_REN];
    assign DOUBLE_RATE_AUDIO = ctrl_reg[`ASD_CTRL_DRA];
    assign L_MAX_GAIN        = lmax_reg;
    assign R_MAX_GAIN        = rmax_reg;
    assign L_CLIP_STEP_EN    = lgtc_reg[`ASD_CLIP_BIT];
    assign R_CLIP_STEP_EN    = rgtc_reg[`ASD_CLIP_BIT];
    assign L_SIG_BELOW       = below_v[0];
    assign R_SIG_BELOW       = below_v[1];

endmodule // asd_agc_regs

// file: test/asd_agc_monitor.sv
`timescale 1ns/1ps
// ****************************************
// port checker for the agc register slice
// ****************************************
module asd_agc_monitor #(
    parameter FS_HZ = 48000
) (
    input logic        CLK,
    input logic        RST,
    input logic        PSEL,
    input logic        PENABLE,
    input logic        PWRITE,
    input logic [7:0]  PADDR,
    input logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic        PSLVERR,
    input logic        L_AGC_EN,
    input logic        R_AGC_EN,
    input logic [6:0]  L_MAX_GAIN,
    input logic        R_CLIP_STEP_EN,
    input logic        R_SIG_BELOW,
    input logic        DOUBLE_RATE_AUDIO
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // write access phase to one byte address
    sequence s_wr(a);
        PSEL && PENABLE && PWRITE && PADDR == a;
    endsequence
    // read access phase
    sequence s_rd;
        PSEL && PENABLE && !PWRITE;
    endsequence
    a_gate_no_err: assert property (PSEL && PENABLE && PADDR == 8'h7C |-> !PSLVERR)
        else $error("mapped gate register refused");
    a_unaligned_err: assert property (s_rd ##0 PADDR[1:0] != 2'h0 |-> PSLVERR && PRDATA == 0)
        else $error("unaligned read not refused");
    a_clip_write: assert property (s_wr(8'h7C) |=> R_CLIP_STEP_EN == $past(PWDATA[0]))
        else $error("clip enable not taken from write");
    a_ctrl_write: assert property (s_wr(8'hC0) |=>
        {DOUBLE_RATE_AUDIO, R_AGC_EN, L_AGC_EN} == $past(PWDATA[2:0]))
        else $error("control bits not taken from write");
    a_max_write: assert property (s_wr(8'hC4) |=> L_MAX_GAIN == $past(PWDATA[7:1]))
        else $error("left max gain not taken from write");
    a_max_reset: assert property ($fell(RST) |-> L_MAX_GAIN == 7'h7F)
        else $error("left max gain reset value wrong");
    a_below_idle: assert property (!R_AGC_EN [*3] |-> !R_SIG_BELOW)
        else $error("below flag set while agc disabled");
    a_dra_cause: assert property ($changed(DOUBLE_RATE_AUDIO) |->
        $past(PSEL && PENABLE && PWRITE && PADDR == 8'hC0))
        else $error("double rate changed without write");
endmodule // asd_agc_monitor

bind asd_agc_regs asd_agc_monitor #(.FS_HZ(FS_HZ)) i_asd_agc_monitor (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .L_AGC_EN(L_AGC_EN), .R_AGC_EN(R_AGC_EN), .L_MAX_GAIN(L_MAX_GAIN),
    .R_CLIP_STEP_EN(R_CLIP_STEP_EN), .R_SIG_BELOW(R_SIG_BELOW),
    .DOUBLE_RATE_AUDIO(DOUBLE_RATE_AUDIO));

// file: test/asd_agc_regs_tb.sv
`timescale 1ns/1ps
`include "asd_consts.vh"
// ****************************************
// bench for the agc register slice
// ****************************************
module asd_agc_regs_tb;
    logic        CLK, RST, PSEL, PENABLE, PWRITE, FS_TICK;
    logic [7:0]  PADDR, L_AGC_GAIN, R_AGC_GAIN;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [6:0]  L_PGA_APPLIED, L_PGA_PROGRAMMED, L_SIG_ATTEN;
    logic [6:0]  R_PGA_APPLIED, R_PGA_PROGRAMMED, R_SIG_ATTEN, L_MAX_GAIN, R_MAX_GAIN;
    logic        L_ADC_POWERED, R_ADC_POWERED, PREADY, PSLVERR, er;
    logic        L_AGC_EN, R_AGC_EN, L_CLIP_STEP_EN, R_CLIP_STEP_EN;
    logic        L_SIG_BELOW, R_SIG_BELOW, DOUBLE_RATE_AUDIO, IRQ;
    logic [1:0]  tick_cnt;
    integer      failures, n_tests, i;

    asd_agc_regs #(.FS_HZ(4000)) i_asd_agc_regs (
        .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .FS_TICK(FS_TICK), .L_AGC_GAIN(L_AGC_GAIN),
        .L_PGA_APPLIED(L_PGA_APPLIED), .L_PGA_PROGRAMMED(L_PGA_PROGRAMMED),
        .L_ADC_POWERED(L_ADC_POWERED), .L_SIG_ATTEN(L_SIG_ATTEN),
        .R_AGC_GAIN(R_AGC_GAIN), .R_PGA_APPLIED(R_PGA_APPLIED),
        .R_PGA_PROGRAMMED(R_PGA_PROGRAMMED), .R_ADC_POWERED(R_ADC_POWERED),
        .R_SIG_ATTEN(R_SIG_ATTEN), .L_AGC_EN(L_AGC_EN), .R_AGC_EN(R_AGC_EN),
        .L_MAX_GAIN(L_MAX_GAIN), .R_MAX_GAIN(R_MAX_GAIN),
        .L_CLIP_STEP_EN(L_CLIP_STEP_EN), .R_CLIP_STEP_EN(R_CLIP_STEP_EN),
        .L_SIG_BELOW(L_SIG_BELOW), .R_SIG_BELOW(R_SIG_BELOW),
        .DOUBLE_RATE_AUDIO(DOUBLE_RATE_AUDIO), .IRQ(IRQ));

    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        integer n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n = n + 1;
        end while (PREADY !== 1'b1 && n < 16);
        if (n == 16)
            failures = failures + 1;
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, {idx, 2'h0}, {24'h0, d});
    endtask

    task rchk(input logic [5:0] idx, input logic [7:0] e);
        apb(1'b0, {idx, 2'h0}, 32'h0);
        check(rd, {24'h0, e});
    endtask

    // let the flag pipeline settle
    task settle;
        repeat (4) @(posedge CLK);
    endtask

    task t_reset;
        for (i = 'h1F; i <= 'h24; i = i + 1)
            rchk(i[5:0], 8'h00);
        rchk(`ASD_IDX_LMAX, 8'hFE);
        check(IRQ, 1'b0);
    endtask

    task t_rw;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ASD_IDX_RGTC, {i[1:0], 6'h07});
            rchk(`ASD_IDX_RGTC, {i[1:0], 6'h07});
            check(R_CLIP_STEP_EN, 1'b1);
        end
        wr(`ASD_IDX_RGTC, 8'h06);
        rchk(`ASD_IDX_RGTC, 8'h06);
        check(R_CLIP_STEP_EN, 1'b0);
        wr(`ASD_IDX_LDEB, 8'hF6);
        rchk(`ASD_IDX_LDEB, 8'hF6);
        wr(`ASD_IDX_RDEB, 8'h3F);
        rchk(`ASD_IDX_RDEB, 8'h3F);
        wr(`ASD_IDX_LGAIN, 8'hFF);
        wr(`ASD_IDX_FLAGS, 8'hFF);
        rchk(`ASD_IDX_LGAIN, 8'h00);
        rchk(`ASD_IDX_FLAGS, 8'h00);
        apb(1'b0, 8'h7D, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
    endtask

    task t_gain;
        @(posedge CLK);
        L_AGC_GAIN <= 8'hE8;
        R_AGC_GAIN <= 8'h77;
        rchk(`ASD_IDX_LGAIN, 8'h00);
        wr(`ASD_IDX_CTRL, 8'h03);
        rchk(`ASD_IDX_LGAIN, 8'hE8);
        rchk(`ASD_IDX_RGAIN, 8'h77);
    endtask

    task t_flags;
        wr(`ASD_IDX_RDEB, 8'h00);
        L_PGA_APPLIED <= 7'h10;
        L_PGA_PROGRAMMED <= 7'h10;
        R_PGA_APPLIED <= 7'h10;
        R_PGA_PROGRAMMED <= 7'h10;
        L_ADC_POWERED <= 1'b1;
        R_ADC_POWERED <= 1'b1;
        R_SIG_ATTEN <= 7'h28;
        wr(`ASD_IDX_RGTC, 8'h02);
        settle;
        rchk(`ASD_IDX_FLAGS, 8'hCF);
        check(R_SIG_BELOW, 1'b1);
        L_PGA_PROGRAMMED <= 7'h11;
        L_ADC_POWERED <= 1'b0;
        L_AGC_GAIN <= 8'h10;
        wr(`ASD_IDX_LMAX, 8'h20);
        settle;
        rchk(`ASD_IDX_FLAGS, 8'h1F);
        R_SIG_ATTEN <= 7'h1D;
        settle;
        check(R_SIG_BELOW, 1'b1);
        R_SIG_ATTEN <= 7'h1C;
        settle;
        check(R_SIG_BELOW, 1'b0);
        wr(`ASD_IDX_RGTC, 8'hC2);
        R_SIG_ATTEN <= 7'h1F;
        settle;
        check(R_SIG_BELOW, 1'b1);
        R_SIG_ATTEN <= 7'h1D;
        settle;
        check(R_SIG_BELOW, 1'b0);
        wr(`ASD_IDX_RGTC, 8'h3E);
        R_SIG_ATTEN <= 7'h5A;
        settle;
        check(R_SIG_BELOW, 1'b0);
        R_SIG_ATTEN <= 7'h5B;
        settle;
        check(R_SIG_BELOW, 1'b1);
        wr(`ASD_IDX_RGTC, 8'h00);
        settle;
        check(R_SIG_BELOW, 1'b0);
    endtask

    task t_irq;
        wr(`ASD_IDX_ICLR, 8'hFF);
        rchk(`ASD_IDX_ISTS, 8'h00);
        wr(`ASD_IDX_IEN, 8'h02);
        wr(`ASD_IDX_RGTC, 8'h02);
        settle;
        check(IRQ, 1'b1);
        rchk(`ASD_IDX_ISTS, 8'h02);
        wr(`ASD_IDX_IEN, 8'hFD);
        @(negedge CLK);
        check(IRQ, 1'b0);
        wr(`ASD_IDX_IEN, 8'h02);
        wr(`ASD_IDX_ICLR, 8'h02);
        rchk(`ASD_IDX_ISTS, 8'h00);
        check(IRQ, 1'b0);
    endtask

    task t_deb;
        wr(`ASD_IDX_RDEB, 8'h18);
        R_SIG_ATTEN <= 7'h00;
        settle;
        R_SIG_ATTEN <= 7'h28;
        repeat (24) @(posedge CLK);
        check(R_SIG_BELOW, 1'b0);
        i = 0;
        while (R_SIG_BELOW !== 1'b1 && i < 16) begin
            @(posedge CLK);
            i = i + 1;
        end
        check(R_SIG_BELOW, 1'b1);
        wr(`ASD_IDX_RDEB, 8'h41);
        R_SIG_ATTEN <= 7'h00;
        repeat (4) @(posedge CLK);
        check(R_SIG_BELOW, 1'b1);
        i = 0;
        while (R_SIG_BELOW !== 1'b0 && i < 8) begin
            @(posedge CLK);
            i = i + 1;
        end
        check(R_SIG_BELOW, 1'b0);
        R_SIG_ATTEN <= 7'h28;
        repeat (1000) @(posedge CLK);
        check(R_SIG_BELOW, 1'b0);
        i = 0;
        while (R_SIG_BELOW !== 1'b1 && i < 40) begin
            @(posedge CLK);
            i = i + 1;
        end
        check(R_SIG_BELOW, 1'b1);
        wr(`ASD_IDX_CTRL, 8'h07);
        rchk(`ASD_IDX_CTRL, 8'h07);
        check(DOUBLE_RATE_AUDIO, 1'b1);
        check(R_MAX_GAIN, 7'h7F);
        check(PREADY, 1'b1);
        wr(`ASD_IDX_LGTC, 8'h01);
        rchk(`ASD_IDX_LGTC, 8'h01);
        check(L_CLIP_STEP_EN, 1'b1);
        check(L_SIG_BELOW, 1'b0);
    endtask

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // sample pulse every fourth clock
    always @(posedge CLK) begin
        tick_cnt <= tick_cnt + 2'h1;
        FS_TICK <= (tick_cnt == 2'h3);
    end

    initial begin
        #40000;
        failures = failures + 1;
        print_verdict;
    end

    initial begin
        failures = 0;
        n_tests = 0;
        tick_cnt = 2'h0;
        {RST, PSEL, PENABLE, PWRITE, FS_TICK} = 5'h10;
        {PADDR, PWDATA, L_AGC_GAIN, R_AGC_GAIN} = 56'h0;
        {L_PGA_APPLIED, L_PGA_PROGRAMMED, L_SIG_ATTEN} = 21'h00080;
        {R_PGA_APPLIED, R_PGA_PROGRAMMED, R_SIG_ATTEN} = 21'h00080;
        {L_ADC_POWERED, R_ADC_POWERED} = 2'h0;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        t_reset;
        t_rw;
        t_gain;
        t_flags;
        t_irq;
        t_deb;
        print_verdict;
    end
endmodule // asd_agc_regs_tb
